// ---- include/mss_pkg.sv ----
package mss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 20_000_000;  // Core clock, 50 ns
  localparam int unsigned CLKS_PER_MC  = 4;           // Clocks per machine cycle
  localparam int unsigned STRETCH_W    = 3;           // Stretch field width
  localparam int unsigned ROM_BYTES    = 32768;       // On-chip program store
  localparam int unsigned XRAM_BYTES   = 1024;        // On-chip data SRAM

  // ----------------------------------------------------------------
  // Special register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_P0    = 8'h80;  // Low address/data port latch
  localparam logic [7:0] SFR_DPL   = 8'h82;  // First pointer low
  localparam logic [7:0] SFR_DPH   = 8'h83;  // First pointer high
  localparam logic [7:0] SFR_SECOND_POINTER_LOW  = 8'h84;  // Second pointer low
  localparam logic [7:0] SFR_SECOND_POINTER_HIGH  = 8'h85;  // Second pointer high
  localparam logic [7:0] SFR_DPS   = 8'h86;  // Pointer select
  localparam logic [7:0] SFR_CKCON = 8'h8E;  // Move stretch control
  localparam logic [7:0] SFR_P2    = 8'hA0;  // High address port latch
  localparam logic [7:0] SFR_PMR   = 8'hC4;  // power_management_register

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PMR_SRAM_EN_BIT = 0;      // internal_sram_enable
  localparam int unsigned PMR_WAIT_EN_BIT = 1;      // Wait-state input enable
  localparam int unsigned DPS_SEL_BIT     = 0;      // Pointer select bit
  localparam logic [7:0]  PMR_RST         = 8'h00;  // SRAM and wait off
  localparam logic [7:0]  CKCON_RST       = 8'h01;  // Three-cycle moves
  localparam logic [7:0]  PORT_RST        = 8'hFF;  // Low port released, high port driven high

  // ----------------------------------------------------------------
  // Opcodes seen by the pointer logic
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PTR_INC = 8'hA3;  // Increment selected pointer
  localparam logic [7:0] OP_PTR_DEC = 8'hA5;  // pointer_decrement_instruction

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    K_FETCH = 2'h0,  // Instruction fetch
    K_TABLE = 2'h1,  // program_table_read
    K_XRD   = 2'h2,  // external_data_move read
    K_XWR   = 2'h3   // external_data_move write
  } kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SYNC = 3'h1,
    ST_ADDR = 3'h3,
    ST_STRB = 3'h2,
    ST_DONE = 3'h6,
    ST_IROM = 3'h4,
    ST_IRAM = 3'h5
  } st_t;

  typedef struct packed {
    logic        valid;
    kind_t       kind;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } req_t;

  typedef struct packed {
    logic       done;
    logic [7:0] rdata;
  } rsp_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } sfr_wr_t;

endpackage : mss_pkg

// ---- design/xram_store.sv ----
module xram_store #(
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  // Clock
  input  wire logic          clk,
  // Access
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_chk
    $error("xram_store depth does not fit the address width");
  end

  logic [7:0] mem_q [DEPTH];  // No reset: contents undefined after power-up

  // Registered read, write-first not needed by the caller
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
    rdata <= mem_q[addr];
  end

endmodule : xram_store

// ---- design/memory_space_steering.sv ----
//
// Contract
// - Enabled SRAM serves data moves 0000H-03FFH.
// - Data moves above 03FFH use external bus.
// - SRAM enabled only by power register bit.
// - Reset clears SRAM enable; all external.
// - Fetches never come from internal SRAM.
// - Scratchpad stays separate from internal SRAM.
// - Fetches below 32K internal while access pin high, else external.
// - Table reads split like instruction fetches.
// - Data space is full 16-bit address.
// - Data move length two to nine cycles.
// - Machine cycle is four clocks.
// - Opcode A5H decrements selected pointer.
// - Two independent 16-bit data pointers.
// - Low port multiplexed on bus, else open-drain.
// - High port drives upper address on bus.
// - Wait input stretches bus when enabled.
// - Write and read strobes for data moves.
// - Program strobe only for external program reads.
// - Address latch strobe pulses each bus access.
// - Internal ROM accesses stay off the bus.
//
module memory_space_steering #(
  parameter int ROM_BYTES  = mss_pkg::ROM_BYTES,
  parameter int XRAM_BYTES = mss_pkg::XRAM_BYTES
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Core side
  input  mss_pkg::req_t         req,
  input  mss_pkg::sfr_wr_t      sfr_wr,
  input  wire logic             op_valid,
  input  wire logic [7:0]       op_code,
  output mss_pkg::rsp_t         rsp,
  output logic                  busy,
  output logic      [15:0]      dptr0,
  output logic      [15:0]      dptr1,
  output logic                  data_pointer_sel,
  // Program store macro
  output logic      [14:0]      rom_addr,
  input  wire logic [7:0]       rom_rdata,
  // External bus pins
  input  wire logic [7:0]       p0_in,
  output logic      [7:0]       p0_out,
  output logic      [7:0]       p0_oe_n,
  output logic      [7:0]       p2_out,
  output logic      [7:0]       p2_oe_n,
  output logic                  ale,
  output logic                  program_store_strobe_n,
  output logic                  wr_n,
  output logic                  rd_n,
  input  wire logic             wait_pin,
  input  wire logic             ext_access_sel
);

  // ----------------------------------------------------------------
  // Elaboration checks and decode helpers
  // ----------------------------------------------------------------
  if (ROM_BYTES < 1 || ROM_BYTES > 32768 || XRAM_BYTES < 1 || XRAM_BYTES > 1024)
  begin : g_chk
    $error("memory_space_steering sizes outside what the ports carry");
  end

  localparam logic [16:0] ROM_LIMIT  = 17'(ROM_BYTES);   // First external code byte
  localparam logic [16:0] XRAM_LIMIT = 17'(XRAM_BYTES);  // First external data byte

  // Code space: internal only while the access pin allows it
  function automatic logic is_irom(input logic [15:0] a, input logic ea);
    is_irom = ea && ({1'b0, a} < ROM_LIMIT);
  endfunction : is_irom

  // Data space: internal only while software enables the SRAM
  function automatic logic is_iram(input logic [15:0] a, input logic en);
    is_iram = en && ({1'b0, a} < XRAM_LIMIT);
  endfunction : is_iram

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [9:0] pin_s1_q;  // First stage, read only by second
  logic [9:0] pin_s2_q;  // Safe copies
  logic [7:0] p0_s;      // Port data as seen by logic
  logic       wait_s;    // Wait request
  logic       ea_s;      // Internal program store allowed

  // Two flops on every pin input
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= 10'h000;
      pin_s2_q <= 10'h000;
    end else begin
      pin_s1_q <= {ext_access_sel, wait_pin, p0_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign p0_s   = pin_s2_q[7:0];
  assign wait_s = pin_s2_q[8];
  assign ea_s   = pin_s2_q[9];

  // ----------------------------------------------------------------
  // Machine cycle phase
  // ----------------------------------------------------------------
  logic [1:0] phase_q;  // Clock within machine cycle

  // Free-running four-clock count paces every bus step
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers written by the core
  // ----------------------------------------------------------------
  logic [7:0] pmr_q;    // power_management_register
  logic [7:0] ckcon_q;  // Stretch control
  logic [7:0] p0_lat_q; // Low port latch
  logic [7:0] p2_lat_q; // High port latch
  logic       sram_en;  // internal_sram_enable
  logic       wait_en;  // Wait pin becomes bus input

  // Only these four registers live here; the scratchpad belongs to the core
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pmr_q    <= mss_pkg::PMR_RST;
      ckcon_q  <= mss_pkg::CKCON_RST;
      p0_lat_q <= mss_pkg::PORT_RST;
      p2_lat_q <= mss_pkg::PORT_RST;
    end else if (sfr_wr.we) begin
      case (sfr_wr.addr)
        mss_pkg::SFR_PMR:   pmr_q    <= sfr_wr.data;
        mss_pkg::SFR_CKCON: ckcon_q  <= sfr_wr.data;
        mss_pkg::SFR_P0:    p0_lat_q <= sfr_wr.data;
        mss_pkg::SFR_P2:    p2_lat_q <= sfr_wr.data;
        default: ;
      endcase
    end
  end

  assign sram_en = pmr_q[mss_pkg::PMR_SRAM_EN_BIT];
  assign wait_en = pmr_q[mss_pkg::PMR_WAIT_EN_BIT];

  // ----------------------------------------------------------------
  // Dual data pointers
  // ----------------------------------------------------------------
  logic [15:0] dp_q [2];  // Pointer pair
  logic        dps_q;     // Active pointer

  // Opcodes first; a byte write in the same cycle as an increment or decrement opcode is dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dp_q[0] <= 16'h0000;
      dp_q[1] <= 16'h0000;
      dps_q   <= 1'b0;
    end else if (op_valid && op_code == mss_pkg::OP_PTR_DEC) begin
      dp_q[dps_q] <= dp_q[dps_q] - 16'h0001;
    end else if (op_valid && op_code == mss_pkg::OP_PTR_INC) begin
      dp_q[dps_q] <= dp_q[dps_q] + 16'h0001;
    end else if (sfr_wr.we) begin
      case (sfr_wr.addr)
        mss_pkg::SFR_DPL:  dp_q[0][7:0]  <= sfr_wr.data;
        mss_pkg::SFR_DPH:  dp_q[0][15:8] <= sfr_wr.data;
        mss_pkg::SFR_SECOND_POINTER_LOW: dp_q[1][7:0]  <= sfr_wr.data;
        mss_pkg::SFR_SECOND_POINTER_HIGH: dp_q[1][15:8] <= sfr_wr.data;
        mss_pkg::SFR_DPS:  dps_q <= sfr_wr.data[mss_pkg::DPS_SEL_BIT];
        default: ;
      endcase
    end
  end

  assign dptr0    = dp_q[0];
  assign dptr1    = dp_q[1];
  assign data_pointer_sel = dps_q;

  // ----------------------------------------------------------------
  // On-chip data SRAM
  // ----------------------------------------------------------------
  mss_pkg::st_t  st_q;     // Access sequencer
  mss_pkg::kind_t kind_q;  // Access kind held for the whole access
  logic [15:0]   addr_q;   // Full 16-bit address
  logic [7:0]    wdata_q;  // Write data
  logic [7:0]    xram_rdata;
  logic          xram_we;
  logic          sub_q;    // Second cycle of internal access
  localparam int unsigned STRETCH_W = mss_pkg::STRETCH_W;  // Stretch field width

  // Write only in the first cycle of an SRAM access
  assign xram_we = (st_q == mss_pkg::ST_IRAM) && !sub_q && (kind_q == mss_pkg::K_XWR);

  xram_store #(
    .DEPTH (XRAM_BYTES),
    .AW    (10)
  ) u_xram (
    .clk   (clk),
    .we    (xram_we),
    .addr  (addr_q[9:0]),
    .wdata (wdata_q),
    .rdata (xram_rdata)
  );

  // ----------------------------------------------------------------
  // Access sequencer and bus pins
  // ----------------------------------------------------------------
  logic [STRETCH_W-1:0] mc_q;    // Strobe machine cycles left
  logic [STRETCH_W-1:0] len_q;   // Strobe length chosen at start
  logic                 last_mc; // Final clock of a machine cycle

  assign last_mc = (phase_q == 2'h3);

  // One process owns every pin so drive changes never overlap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q     <= mss_pkg::ST_IDLE;
      kind_q   <= mss_pkg::K_FETCH;
      addr_q   <= 16'h0000;
      wdata_q  <= 8'h00;
      sub_q    <= 1'b0;
      mc_q     <= '0;
      len_q    <= '0;
      busy     <= 1'b0;
      rsp      <= '0;
      rom_addr <= 15'h0000;
      p0_out   <= mss_pkg::PORT_RST;
      p0_oe_n  <= 8'hFF;
      p2_out   <= mss_pkg::PORT_RST;
      p2_oe_n  <= 8'h00;
      ale      <= 1'b0;
      program_store_strobe_n   <= 1'b1;
      wr_n     <= 1'b1;
      rd_n     <= 1'b1;
    end else begin
      rsp.done <= 1'b0;
      case (st_q)
        mss_pkg::ST_IDLE: begin
          // Ports follow their latches; low port is open-drain here
          p0_out  <= p0_lat_q;
          p0_oe_n <= p0_lat_q;
          p2_out  <= p2_lat_q;
          p2_oe_n <= 8'h00;
          if (req.valid) begin
            kind_q  <= req.kind;
            addr_q  <= req.addr;
            wdata_q <= req.wdata;
            busy    <= 1'b1;
            sub_q   <= 1'b0;
            if (req.kind == mss_pkg::K_XRD || req.kind == mss_pkg::K_XWR) begin
              // Data moves: SRAM window or external bus
              if (is_iram(req.addr, sram_en)) begin
                st_q <= mss_pkg::ST_IRAM;
              end else begin
                st_q <= mss_pkg::ST_SYNC;
              end
            end else if (is_irom(req.addr, ea_s)) begin
              // Code and table reads never look at the SRAM
              st_q     <= mss_pkg::ST_IROM;
              rom_addr <= req.addr[14:0];
            end else begin
              st_q <= mss_pkg::ST_SYNC;
            end
          end
        end
        mss_pkg::ST_IROM: begin
          // Pins untouched: the program store stays private
          sub_q <= 1'b1;
          if (sub_q) begin
            rsp.done  <= 1'b1;
            rsp.rdata <= rom_rdata;
            busy      <= 1'b0;
            st_q      <= mss_pkg::ST_IDLE;
          end
        end
        mss_pkg::ST_IRAM: begin
          // No strobe moves while the SRAM answers
          sub_q <= 1'b1;
          if (sub_q) begin
            rsp.done  <= 1'b1;
            rsp.rdata <= xram_rdata;
            busy      <= 1'b0;
            st_q      <= mss_pkg::ST_IDLE;
          end
        end
        mss_pkg::ST_SYNC: begin
          // Wait for a machine cycle boundary, then put out the address
          if (last_mc) begin
            st_q    <= mss_pkg::ST_ADDR;
            ale     <= 1'b1;
            p0_out  <= addr_q[7:0];
            p0_oe_n <= 8'h00;
            p2_out  <= addr_q[15:8];
            p2_oe_n <= 8'h00;
            if (kind_q == mss_pkg::K_XRD || kind_q == mss_pkg::K_XWR) begin
              mc_q  <= ckcon_q[STRETCH_W-1:0];
              len_q <= ckcon_q[STRETCH_W-1:0];
            end else begin
              mc_q  <= '0;
              len_q <= '0;
            end
          end
        end
        mss_pkg::ST_ADDR: begin
          // Latch strobe covers the first half cycle of address time
          if (phase_q == 2'h1) begin
            ale <= 1'b0;
          end
          if (last_mc) begin
            st_q <= mss_pkg::ST_STRB;
            case (kind_q)
              mss_pkg::K_XWR: begin
                p0_out <= wdata_q;
                wr_n   <= 1'b0;
              end
              mss_pkg::K_XRD: begin
                p0_oe_n <= 8'hFF;
                rd_n    <= 1'b0;
              end
              default: begin
                p0_oe_n <= 8'hFF;
                program_store_strobe_n  <= 1'b0;
              end
            endcase
          end
        end
        mss_pkg::ST_STRB: begin
          // Wait is sampled at each cycle end; it adds whole cycles
          if (last_mc && !(wait_en && wait_s)) begin
            if (mc_q == '0) begin
              st_q      <= mss_pkg::ST_DONE;
              rd_n      <= 1'b1;
              wr_n      <= 1'b1;
              program_store_strobe_n    <= 1'b1;
              rsp.rdata <= p0_s;  // Pin value from the strobe's last clocks
            end else begin
              mc_q <= mc_q - 1'b1;
            end
          end
        end
        mss_pkg::ST_DONE: begin
          rsp.done <= 1'b1;
          busy     <= 1'b0;
          p0_out   <= p0_lat_q;
          p0_oe_n  <= p0_lat_q;
          p2_out   <= p2_lat_q;
          st_q     <= mss_pkg::ST_IDLE;
        end
        default: begin
          st_q <= mss_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic       take;      // Request taken this cycle
  logic [5:0] strb_cnt_q; // Clocks with a data strobe low

  assign take = (st_q == mss_pkg::ST_IDLE) && req.valid;

  // Length of the current data strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strb_cnt_q <= 6'h00;
    end else begin
      strb_cnt_q <= (!rd_n || !wr_n) ? strb_cnt_q + 6'h01 : 6'h00;
    end
  end

  a_low_to_sram: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.kind[1] && sram_en && req.addr <= 16'h03FF |=> st_q == mss_pkg::ST_IRAM)
    else $error("low data move missed internal SRAM");

  a_high_to_bus: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.kind[1] && req.addr > 16'h03FF |=> st_q == mss_pkg::ST_SYNC)
    else $error("high data move not sent to the bus");

  a_sram_needs_en: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(st_q == mss_pkg::ST_IRAM) |-> $past(sram_en))
    else $error("internal SRAM used while disabled");

  a_reset_clears_en: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n) |-> !sram_en)
    else $error("SRAM enable set after reset");

  a_fetch_not_sram: assert property (@(posedge clk) disable iff (!arst_n)
    take && !req.kind[1] |=> st_q != mss_pkg::ST_IRAM)
    else $error("code read served from data SRAM");

  a_rom_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    st_q == mss_pkg::ST_IROM |-> program_store_strobe_n && !ale && $stable(p2_out))
    else $error("internal code read visible on the bus");

  a_ale_aligned: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(ale) |-> phase_q == 2'h0 ##1 ale ##1 !ale)
    else $error("address strobe off the machine cycle");

  a_strobe_len: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(rd_n && wr_n) && !wait_en |-> strb_cnt_q == {1'b0, len_q + 3'h1, 2'h0})
    else $error("data strobe length wrong");

  a_wait_holds: assert property (@(posedge clk) disable iff (!arst_n)
    st_q == mss_pkg::ST_STRB && last_mc && wait_en && wait_s |=> st_q == mss_pkg::ST_STRB)
    else $error("wait request ignored");

  a_ptr_dec: assert property (@(posedge clk) disable iff (!arst_n)
    op_valid && op_code == mss_pkg::OP_PTR_DEC && !dps_q
    |=> dp_q[0] == $past(dp_q[0]) - 16'h0001)
    else $error("pointer decrement wrong");

  a_addr_drive: assert property (@(posedge clk) disable iff (!arst_n)
    st_q == mss_pkg::ST_ADDR |-> p0_oe_n == 8'h00 && p2_oe_n == 8'h00 && p2_out == addr_q[15:8])
    else $error("address not driven on both ports");

  a_program_store_strobe_code: assert property (@(posedge clk) disable iff (!arst_n)
    !program_store_strobe_n |-> !kind_q[1] && rd_n && wr_n && p0_oe_n == 8'hFF)
    else $error("program strobe on a data access");

  a_sram_no_strb: assert property (@(posedge clk) disable iff (!arst_n)
    st_q == mss_pkg::ST_IRAM |-> rd_n && wr_n && program_store_strobe_n)
    else $error("strobe during internal SRAM access");

endmodule : memory_space_steering

// ---- tb/ext_mem_model.sv ----
module ext_mem_model (
  // Bus pins from the block
  input  wire logic       ale,
  input  wire logic       program_store_strobe_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p0_oe_n,
  input  wire logic [7:0] p2_out,
  // Level seen back on the low port
  output logic      [7:0] p0_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  lo_q;                  // Latched low address
  logic [7:0]  last_q = 8'h00;        // Last byte we drove
  logic [7:0]  mem [logic [15:0]];    // Sparse external store
  logic [15:0] a;                     // Full bus address
  logic [7:0]  dat;                   // Byte answered
  assign a   = {p2_out, lo_q};
  // Unwritten bytes answer a pattern made from the address
  assign dat = mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8]);
  // Latch low byte as the strobe falls
  always @(negedge ale) lo_q = p0_out;
  // Capture write data at the end of the strobe
  always @(posedge wr_n) if (!$isunknown(a)) mem[a] = p0_out;
  always @(posedge rd_n or posedge program_store_strobe_n) last_q = dat;
  // Released bits show the inverse, so stale data never passes
  always_comb begin
    if (!program_store_strobe_n || !rd_n) p0_in = dat;
    else p0_in = (p0_out & ~p0_oe_n) | (~last_q & p0_oe_n);
  end
endmodule : ext_mem_model

// ---- tb/memory_space_steering_tb.sv ----
module memory_space_steering_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, op_valid = 0, wait_pin = 0, eas = 0;
  logic [7:0] op_code = 8'h00, rom_rdata = 8'h00, p0_in, rd;
  mss_pkg::req_t    req = '0;
  mss_pkg::sfr_wr_t sfr = '0;
  mss_pkg::rsp_t    rsp;
  logic busy, dsel, ale, program_store_strobe_n, wr_n, rd_n;
  logic [15:0] dp0, dp1;
  logic [14:0] rom_addr;
  logic [7:0]  p0_out, p0_oe_n, p2_out, p2_oe_n;
  int failures = 0, check_count = 0, st, ps;
  memory_space_steering DUT (.clk(clk), .arst_n(arst_n), .req(req), .sfr_wr(sfr),
    .op_valid(op_valid), .op_code(op_code), .rsp(rsp), .busy(busy), .dptr0(dp0),
    .dptr1(dp1), .data_pointer_sel(dsel), .rom_addr(rom_addr), .rom_rdata(rom_rdata),
    .p0_in(p0_in), .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p2_out(p2_out),
    .p2_oe_n(p2_oe_n), .ale(ale), .program_store_strobe_n(program_store_strobe_n), .wr_n(wr_n), .rd_n(rd_n),
    .wait_pin(wait_pin), .ext_access_sel(eas));
  ext_mem_model u_mem (.ale(ale), .program_store_strobe_n(program_store_strobe_n), .rd_n(rd_n), .wr_n(wr_n),
    .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p2_out(p2_out), .p0_in(p0_in));
  // Clock, 50 ns period
  always #25 clk = ~clk;
  // Synchronous program store with a known pattern
  always_ff @(posedge clk) rom_rdata <= rom_addr[7:0] ^ 8'h5A;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One register write, one cycle long
  task automatic wsfr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk) sfr <= '{1'b1, ad, d};
    @(posedge clk) sfr.we <= 1'b0;
  endtask : wsfr
  // One access; counts data strobe and program strobe cycles
  task automatic acc(input mss_pkg::kind_t k, input logic [15:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    st = 0;
    ps = 0;
    @(posedge clk) req <= '{1'b1, k, a, wd};
    @(posedge clk) req.valid <= 1'b0;
    while (n < 300) begin
      @(negedge clk);
      if (!rd_n || !wr_n) st++;
      if (!program_store_strobe_n) ps++;
      if (rsp.done === 1'b1) break;
      n++;
    end
    if (n == 300) begin
      failures++;
      print_verdict();
    end
    rd = rsp.rdata;
  endtask : acc
  // Data moves: default routing, internal store, stretch
  task automatic t_data();
    acc(mss_pkg::K_XWR, 16'h0010, 8'h3C);
    chk("ext wr strobe", st, 8);
    chk("ext mem", u_mem.mem[16'h0010], 8'h3C);
    wsfr(mss_pkg::SFR_PMR, 8'h01);
    acc(mss_pkg::K_XWR, 16'h0010, 8'hA7);
    chk("int wr strobe", st, 0);
    acc(mss_pkg::K_XRD, 16'h0010, 8'h00);
    chk("int rd", rd, 8'hA7);
    chk("ext mem kept", u_mem.mem[16'h0010], 8'h3C);
    acc(mss_pkg::K_XRD, 16'h0400, 8'h00);
    chk("above sram", rd, 8'h04);
    acc(mss_pkg::K_XRD, 16'hFF12, 8'h00);
    chk("top addr", rd, 8'hED);
    wsfr(mss_pkg::SFR_CKCON, 8'h00);
    acc(mss_pkg::K_XRD, 16'h03FF, 8'h00);
    wsfr(mss_pkg::SFR_PMR, 8'h00);
    acc(mss_pkg::K_XRD, 16'h0010, 8'h00);
    chk("sram off", rd, 8'h3C);
    chk("short strobe", st, 4);
    chk("idle busy", busy, 0);
    wsfr(mss_pkg::SFR_PMR, 8'h02);
    wait_pin <= 1'b1;
    fork
      acc(mss_pkg::K_XRD, 16'h0010, 8'h00);
      begin
        repeat (20) @(posedge clk);
        wait_pin <= 1'b0;
      end
    join
    chk("wait stretch", st > 4, 1);
    chk("wait data", rd, 8'h3C);
  endtask : t_data
  // Fetches and table reads split at the on-chip store limit
  task automatic t_prog();
    eas <= 1'b1;
    repeat (3) @(posedge clk);
    acc(mss_pkg::K_FETCH, 16'h0100, 8'h00);
    chk("irom data", rd, 8'h5A);
    chk("irom program_store_strobe", ps, 0);
    acc(mss_pkg::K_TABLE, 16'h7FFF, 8'h00);
    chk("itab data", rd, 8'hA5);
    acc(mss_pkg::K_TABLE, 16'h8123, 8'h00);
    chk("xtab data", rd, 8'hA2);
    chk("xtab program_store_strobe", ps > 0, 1);
    wsfr(mss_pkg::SFR_PMR, 8'h01);
    eas <= 1'b0;
    repeat (3) @(posedge clk);
    acc(mss_pkg::K_FETCH, 16'h0010, 8'h00);
    chk("no sram fetch", rd, 8'h3C);
  endtask : t_prog
  // Pointer decrement and second pointer
  task automatic t_ptr();
    @(posedge clk) begin
      op_valid <= 1'b1;
      op_code  <= mss_pkg::OP_PTR_DEC;
    end
    @(posedge clk) op_valid <= 1'b0;
    wsfr(mss_pkg::SFR_DPS, 8'h01);
    wsfr(mss_pkg::SFR_SECOND_POINTER_LOW, 8'h34);
    wsfr(mss_pkg::SFR_SECOND_POINTER_HIGH, 8'h12);
    @(posedge clk) op_valid <= 1'b1;
    @(posedge clk) op_valid <= 1'b0;
    @(negedge clk);
    chk("dptr0", dp0, 16'hFFFF);
    chk("dptr1", dp1, 16'h1233);
    chk("data_pointer sel", dsel, 1);
  endtask : t_ptr
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk("p0 oe", p0_oe_n, 8'hFF);
    chk("p2 oe", p2_oe_n, 8'h00);
    t_data();
    t_prog();
    t_ptr();
    print_verdict();
  end
endmodule : memory_space_steering_tb
